// [remap_status_pkg.sv]
// How it works
// - command bit 23 would pick block or pass-through for compatibility irqs
// - each update of that command bit would show in status bit 23
// - compatibility irq control unsupported: command and status bit read 0
// - status bit 31 follows translation enable
// - status bit 30 clears when set-root-pointer command is issued
// - status bit 30 sets once the root pointer has been latched
// - status bit 29 clears on set-fault-log, sets once pointer loaded
// - status bit 28 follows advanced fault logging enable
// - status bit 27 sets when a flush command is issued
// - status bit 27 clears only once the flush has fully completed
// - status bit 26 follows queued invalidation enable
// - status bit 25 follows interrupt remapping enable
// - status bit 24 clears on set-irq-table-pointer command
// - status bit 24 sets once the irq table pointer has been loaded
// - status bit 23 is held at zero; compatibility irq handling state is not reported
// - status word is 32-bit read-only, resets to zero, bits 22:0 zero
// - flush command honoured only where flushing is needed
package remap_status_pkg;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h1C;
    localparam logic [7:0]  COMMAND_OFFSET  = 8'h18;
    localparam logic [7:0]  ENABLES_OFFSET  = 8'h30;
    localparam logic [31:0] STATUS_RESET    = 32'h00000000;
    localparam int          TRANS_ON_BIT    = 31;
    localparam int          ROOT_DONE_BIT   = 30;
    localparam int          FLOG_DONE_BIT   = 29;
    localparam int          ADV_LOG_ON_BIT  = 28;
    localparam int          FLUSH_BUSY_BIT  = 27;
    localparam int          QINVAL_ON_BIT   = 26;
    localparam int          IRQ_REMAP_BIT   = 25;
    localparam int          IRQT_DONE_BIT   = 24;
    localparam int          COMPAT_BIT      = 23;
    // command word strobe positions
    localparam int          ROOT_CMD_BIT    = 30;
    localparam int          FLOG_CMD_BIT    = 29;
    localparam int          FLUSH_CMD_BIT   = 27;
    localparam int          IRQT_CMD_BIT    = 24;
    localparam int          EN_TRANS_BIT    = 0;
    localparam int          EN_AFL_BIT      = 1;
    localparam int          EN_QI_BIT       = 2;
    localparam int          EN_IRQ_BIT      = 3;
    localparam logic [3:0]  ENABLES_RESET   = 4'h0;
    // operation latency, cycles
    localparam logic [3:0]  OP_CYCLES       = 4'h4;
    localparam logic [3:0]  FLUSH_CYCLES    = 4'h8;
    localparam bit          HAS_ADV_LOG     = 1'b1;
    localparam bit          NEEDS_FLUSH     = 1'b1;
endpackage : remap_status_pkg

// [op_timer.sv]
`timescale 1ns/1ns
// one pending operation: done pulses after a fixed latency
module op_timer
(
    input  wire logic       clock_i,
    input  wire logic       sys_rst_i,
    input  wire logic       start_i,
    input  wire logic [3:0] cycles_i,
    output logic            busy_o,
    output logic            done_o
);
    logic [3:0] cnt_q;
    logic [3:0] cnt_d;
    logic       done_q;
    logic       done_d;

    // restart on every start, count down to zero
    always_comb
    begin
        cnt_d  = cnt_q;
        done_d = 1'b0;
        if (start_i)
        begin
            cnt_d = cycles_i;
        end
        else if (cnt_q != 4'h0)
        begin
            cnt_d  = cnt_q - 4'h1;
            done_d = (cnt_q == 4'h1);
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            cnt_q  <= 4'h0;
            done_q <= 1'b0;
        end
        else
        begin
            cnt_q  <= cnt_d;
            done_q <= done_d;
        end
    end

    assign busy_o = (cnt_q != 4'h0);
    assign done_o = done_q;
endmodule : op_timer

// [remap_global_status_bank.sv]
`timescale 1ns/1ns
module remap_global_status_bank
(
    input  wire logic        clock_i,
    input  wire logic        sys_rst_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic [31:0]      rdata_o,
    output logic             compat_irq_passthrough_o
);
    localparam int NOPS = 3;

    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [3:0]  en_q;
    logic [3:0]  en_d;
    logic        root_done_q;
    logic        root_done_d;
    logic        flog_done_q;
    logic        flog_done_d;
    logic        irqt_done_q;
    logic        irqt_done_d;
    logic        flush_busy_q;
    logic        flush_busy_d;
    logic        cmd_wr;
    logic        set_root_pointer_cmd;
    logic        set_fault_log_cmd;
    logic        buffer_flush_cmd;
    logic        set_irq_table_pointer_cmd;
    logic [NOPS-1:0] op_start;
    logic [NOPS-1:0] op_done;
    logic [NOPS-1:0] op_busy;
    logic        flush_done;
    logic        flush_timer_busy;
    logic [31:0] status;
    logic [4:0]  flush_run_q;
    logic [4:0]  flush_run_d;

    // all checks below run on the core clock, quiet in reset
    default clocking cb_core @(posedge clock_i);
    endclocking
    default disable iff (sys_rst_i);

    // command strobes from writes to the command word
    assign cmd_wr = wr_i && (addr_i == remap_status_pkg::COMMAND_OFFSET);
    assign set_root_pointer_cmd = cmd_wr
        && wdata_i[remap_status_pkg::ROOT_CMD_BIT];
    assign set_fault_log_cmd = cmd_wr
        && wdata_i[remap_status_pkg::FLOG_CMD_BIT]
        && remap_status_pkg::HAS_ADV_LOG;
    assign buffer_flush_cmd = cmd_wr
        && wdata_i[remap_status_pkg::FLUSH_CMD_BIT]
        && remap_status_pkg::NEEDS_FLUSH;
    assign set_irq_table_pointer_cmd = cmd_wr
        && wdata_i[remap_status_pkg::IRQT_CMD_BIT];
    assign op_start = {set_irq_table_pointer_cmd, set_fault_log_cmd,
                       set_root_pointer_cmd};

    // pointer load latency timers, one per pointer kind
    genvar g;
    generate
        for (g = 0; g < NOPS; g++)
        begin : g_ptr
            op_timer u_ptr
            (
                .clock_i  (clock_i),
                .sys_rst_i(sys_rst_i),
                .start_i  (op_start[g]),
                .cycles_i (remap_status_pkg::OP_CYCLES),
                .busy_o   (op_busy[g]),
                .done_o   (op_done[g])
            );
        end
    endgenerate

    // write-buffer flush engine
    op_timer u_flush
    (
        .clock_i  (clock_i),
        .sys_rst_i(sys_rst_i),
        .start_i  (buffer_flush_cmd),
        .cycles_i (remap_status_pkg::FLUSH_CYCLES),
        .busy_o   (flush_timer_busy),
        .done_o   (flush_done)
    );

    // enable register; only its own offset writes it, status stays as is
    always_comb
    begin
        en_d = en_q;
        if (wr_i && addr_i == remap_status_pkg::ENABLES_OFFSET)
        begin
            en_d = wdata_i[3:0];
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            en_q <= remap_status_pkg::ENABLES_RESET;
        end
        else
        begin
            en_q <= en_d;
        end
    end

    // handshake flags; a new command wins over done
    always_comb
    begin
        root_done_d = root_done_q;
        if (op_done[0])
        begin
            root_done_d = 1'b1;
        end
        if (set_root_pointer_cmd)
        begin
            root_done_d = 1'b0;
        end
        flog_done_d = flog_done_q;
        if (op_done[1])
        begin
            flog_done_d = 1'b1;
        end
        if (set_fault_log_cmd)
        begin
            flog_done_d = 1'b0;
        end
        irqt_done_d = irqt_done_q;
        if (op_done[2])
        begin
            irqt_done_d = 1'b1;
        end
        if (set_irq_table_pointer_cmd)
        begin
            irqt_done_d = 1'b0;
        end
        flush_busy_d = flush_busy_q;
        if (flush_done)
        begin
            flush_busy_d = 1'b0;
        end
        if (buffer_flush_cmd)
        begin
            flush_busy_d = 1'b1;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            root_done_q  <= 1'b0;
            flog_done_q  <= 1'b0;
            irqt_done_q  <= 1'b0;
            flush_busy_q <= 1'b0;
        end
        else
        begin
            root_done_q  <= root_done_d;
            flog_done_q  <= flog_done_d;
            irqt_done_q  <= irqt_done_d;
            flush_busy_q <= flush_busy_d;
        end
    end

    // cycles the flush flag has stood, for the completion bound
    always_comb
    begin
        flush_run_d = 5'h00;
        if (flush_busy_q && !buffer_flush_cmd)
        begin
            flush_run_d = flush_run_q + 5'h01;
        end
    end

    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            flush_run_q <= 5'h00;
        end
        else
        begin
            flush_run_q <= flush_run_d;
        end
    end

    // status word assembly; compat bit held reserved at zero
    always_comb
    begin
        status = remap_status_pkg::STATUS_RESET;
        status[remap_status_pkg::TRANS_ON_BIT] =
            en_q[remap_status_pkg::EN_TRANS_BIT];
        status[remap_status_pkg::ROOT_DONE_BIT] = root_done_q;
        status[remap_status_pkg::FLOG_DONE_BIT] = flog_done_q;
        status[remap_status_pkg::ADV_LOG_ON_BIT] =
            en_q[remap_status_pkg::EN_AFL_BIT]
            && remap_status_pkg::HAS_ADV_LOG;
        status[remap_status_pkg::FLUSH_BUSY_BIT] = flush_busy_q;
        status[remap_status_pkg::QINVAL_ON_BIT] =
            en_q[remap_status_pkg::EN_QI_BIT];
        status[remap_status_pkg::IRQ_REMAP_BIT] =
            en_q[remap_status_pkg::EN_IRQ_BIT];
        status[remap_status_pkg::IRQT_DONE_BIT] = irqt_done_q;
        status[remap_status_pkg::COMPAT_BIT] = 1'b0;
    end

    // read mux; command word reads zero, unmapped reads zero
    always_comb
    begin
        rdata_d = 32'h00000000;
        if (rd_i)
        begin
            case (addr_i)
                remap_status_pkg::STATUS_OFFSET:  rdata_d = status;
                remap_status_pkg::ENABLES_OFFSET: rdata_d = {28'h0000000,
                                                             en_q};
                default:                          rdata_d = 32'h00000000;
            endcase
        end
    end

    // read data register, stands one cycle after the strobe
    always_ff @(posedge clock_i)
    begin
        if (sys_rst_i)
        begin
            rdata_q <= 32'h00000000;
        end
        else
        begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign compat_irq_passthrough_o = 1'b0;

    // pointer handshake flags
    chk_root_clear: assert property (
        set_root_pointer_cmd |=> !root_done_q)
        else $error("root pointer flag not cleared");
    chk_root_set: assert property (
        set_root_pointer_cmd ##1 (!cmd_wr) [*5] |=> root_done_q)
        else $error("root pointer flag not set");
    chk_root_busy: assert property (
        op_busy[0] |-> !root_done_q)
        else $error("root pointer flag set while loading");
    chk_flog_clear: assert property (
        set_fault_log_cmd |=> !flog_done_q)
        else $error("fault log flag not cleared");
    chk_flog_set: assert property (
        op_done[1] && !set_fault_log_cmd |=> flog_done_q)
        else $error("fault log flag wrong");
    chk_flog_busy: assert property (
        op_busy[1] |-> !flog_done_q)
        else $error("fault log flag set while loading");
    chk_irqt_clear: assert property (
        set_irq_table_pointer_cmd |=> !irqt_done_q)
        else $error("irq table flag not cleared");
    chk_irqt_set: assert property (
        op_done[2] && !set_irq_table_pointer_cmd |=> irqt_done_q)
        else $error("irq table flag not set");
    chk_irqt_busy: assert property (
        op_busy[2] |-> !irqt_done_q)
        else $error("irq table flag set while loading");

    // write-buffer flush flag
    chk_flush_set: assert property (
        buffer_flush_cmd |=> flush_busy_q)
        else $error("flush flag not set");
    chk_flush_hold: assert property (
        flush_busy_q && flush_timer_busy |=> flush_busy_q)
        else $error("flush flag cleared early");
    chk_flush_clear: assert property (
        flush_done && !buffer_flush_cmd |=> !flush_busy_q)
        else $error("flush flag not cleared");
    chk_flush_bound: assert property (
        flush_run_q <= 5'(remap_status_pkg::FLUSH_CYCLES) + 5'h01)
        else $error("flush flag stands too long");

    // register reads and ignored writes
    chk_status_read: assert property (
        rd_i && addr_i == remap_status_pkg::STATUS_OFFSET |=>
        rdata_o[22:0] == 23'h000000 && rdata_o[31] == $past(en_q[0]))
        else $error("status read wrong");
    chk_enables_map: assert property (
        rd_i && addr_i == remap_status_pkg::STATUS_OFFSET |=>
        rdata_o[28] == $past(en_q[1]) && rdata_o[26] == $past(en_q[2])
        && rdata_o[25] == $past(en_q[3]))
        else $error("status enable bits wrong");
    chk_status_ro: assert property (
        wr_i && addr_i == remap_status_pkg::STATUS_OFFSET |=>
        en_q == $past(en_q))
        else $error("status write changed state");
    chk_cmd_read_zero: assert property (
        rd_i && addr_i == remap_status_pkg::COMMAND_OFFSET |=>
        rdata_o == 32'h00000000)
        else $error("command read not zero");
    chk_idle_read: assert property (
        !rd_i |=> rdata_o == 32'h00000000)
        else $error("read data stands too long");
    chk_compat_zero: assert property (
        !rdata_o[23])
        else $error("compat state bit set");
    chk_compat_out: assert property (
        !compat_irq_passthrough_o)
        else $error("compat pass-through raised");
endmodule : remap_global_status_bank

// [tb_remap_global_status_bank.sv]
`timescale 1ns/1ns
module tb_remap_global_status_bank;
    localparam logic [7:0] A_ST  = remap_status_pkg::STATUS_OFFSET;
    localparam logic [7:0] A_CMD = remap_status_pkg::COMMAND_OFFSET;
    localparam logic [7:0] A_EN  = remap_status_pkg::ENABLES_OFFSET;
    logic        clock_i   = 1'b0;
    logic        sys_rst_i = 1'b1;
    logic [7:0]  addr_i    = 8'h00;
    logic [31:0] wdata_i   = 32'h00000000;
    logic        wr_i      = 1'b0;
    logic        rd_i      = 1'b0;
    logic [31:0] rdata_o;
    logic        compat_irq_passthrough_o;
    logic [31:0] seen;
    logic [31:0] exp_st;
    logic        pend;
    int          miscompares = 0;
    int          compares    = 0;
    int          cycles      = 0;
    int          cmd_bits [4];

    remap_global_status_bank dut
    (
        .clock_i                  (clock_i),
        .sys_rst_i                (sys_rst_i),
        .addr_i                   (addr_i),
        .wdata_i                  (wdata_i),
        .wr_i                     (wr_i),
        .rd_i                     (rd_i),
        .rdata_o                  (rdata_o),
        .compat_irq_passthrough_o (compat_irq_passthrough_o)
    );

    // 50 ns clock
    always #25 clock_i = ~clock_i;

    // hang guard
    always @(posedge clock_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            miscompares++;
            report_and_stop();
        end
    end

    task report_and_stop;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : report_and_stop

    task check(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            miscompares++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask : check

    // one-cycle write strobe
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge clock_i);
        wr_i    <= 1'b0;
    endtask : wr_reg

    // one-cycle read strobe, data sampled in the following cycle
    task rd_reg(input logic [7:0] a);
        @(posedge clock_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge clock_i);
        rd_i   <= 1'b0;
        #1 seen = rdata_o;
    endtask : rd_reg

    // expected status for a given enables word
    function automatic logic [31:0] en_status(input logic [3:0] en);
        en_status = 32'h00000000;
        en_status[remap_status_pkg::TRANS_ON_BIT]   = en[0];
        en_status[remap_status_pkg::ADV_LOG_ON_BIT] = en[1];
        en_status[remap_status_pkg::QINVAL_ON_BIT]  = en[2];
        en_status[remap_status_pkg::IRQ_REMAP_BIT]  = en[3];
    endfunction : en_status

    // bounded poll of one status bit
    task poll(input int b, input logic v);
        int n;
        n = 0;
        rd_reg(A_ST);
        while (seen[b] !== v && n < 12)
        begin
            rd_reg(A_ST);
            n++;
        end
    endtask : poll

    // main sequence
    initial
    begin
        cmd_bits = '{remap_status_pkg::ROOT_DONE_BIT,
                     remap_status_pkg::FLOG_DONE_BIT,
                     remap_status_pkg::FLUSH_BUSY_BIT,
                     remap_status_pkg::IRQT_DONE_BIT};
        repeat (10) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd_reg(A_ST);
        check("status reset", seen, remap_status_pkg::STATUS_RESET);
        rd_reg(A_CMD);
        check("command read", seen, 32'h00000000);
        // each enable alone, then all
        for (int i = 0; i < 4; i++)
        begin
            wr_reg(A_EN, 32'h00000001 << i);
            rd_reg(A_ST);
            check("en map", seen, en_status(4'h1 << i));
        end
        wr_reg(A_EN, 32'h0000000F);
        exp_st = en_status(4'hF);
        rd_reg(A_EN);
        check("enables", seen, 32'h0000000F);
        // unsupported compat control stays zero
        wr_reg(A_CMD, 32'h00800000);
        rd_reg(A_ST);
        check("compat state", seen, exp_st);
        check("compat out", {31'h0, compat_irq_passthrough_o}, 32'h0);
        // writes to status and unmapped places ignored
        wr_reg(A_ST, 32'hFFFFFFFF);
        wr_reg(8'h40, 32'hFFFFFFFF);
        rd_reg(8'h40);
        check("unmapped", seen, 32'h00000000);
        rd_reg(A_ST);
        check("status ro", seen, exp_st);
        wr_reg(A_CMD, 32'h00000000);
        rd_reg(A_ST);
        check("cmd clear", seen, exp_st);
        // each command twice: pending state, then completion
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 4; i++)
            begin
                pend = (cmd_bits[i] == remap_status_pkg::FLUSH_BUSY_BIT);
                wr_reg(A_CMD, 32'h00000001 << cmd_bits[i]);
                rd_reg(A_ST);
                exp_st[cmd_bits[i]] = pend;
                check("cmd pending", seen, exp_st);
                exp_st[cmd_bits[i]] = ~pend;
                poll(cmd_bits[i], ~pend);
                check("cmd done", seen, exp_st);
            end
        // reset in mid flush
        wr_reg(A_CMD, 32'h08000000);
        @(posedge clock_i);
        sys_rst_i <= 1'b1;
        @(posedge clock_i);
        sys_rst_i <= 1'b0;
        rd_reg(A_ST);
        check("mid reset", seen, remap_status_pkg::STATUS_RESET);
        report_and_stop();
    end
endmodule : tb_remap_global_status_bank
